// file: rtl/dcms_top.v
// Clock source enable, crystal settle timer, clock monitor and glitch-free selector.
//
// How it works
// - Crystal amplifier enabled only with outside_gen_on set and no stop mode.
// - Outside clock input path enabled only with outside_gen_on and no stop.
// - Monitor flags a clock dead when it stops or runs too slow.
// - monitor_on sets only with both generators on and both stable.
// - Once on, monitor stays on although a stable indication drops.
// - Reference divide ratios follow low_freq_crystal_sel once outside is stable.
// - Both clocks always divided by four; long divider placed by crystal select.
// - Long divider held cleared while outside_gen_active is clear.
// - Before stable, long divider counts outside_clock; outside reference is off.
// - Falling edge of settle clock, after 4096 cycles, sets outside_gen_stable.
// - Losing outside stability returns long divider to settle duty.
// - onchip_clock_dead after two silent outside reference low phases.
// - onchip_gen_stable after two in-range period measurements; cleared otherwise.
// - outside_clock_dead after two silent onchip reference low phases.
// - outside_gen_stable clears when outside_gen_on clears or clock dead.
// - Selector takes outside clock on select one, onchip clock on zero.
// - Select writes take effect only with both generators on and target stable.
// - halved_out_clock is the selected clock divided by two.
// - Switch finishes old clock, holds low, then follows new clock.
// - Switch selects onchip clock during reset.
// - Monitor forces dead side off and selects the live clock.
// - Generator active only while its on bit set and clocks not halted.
`timescale 1ns/100ps
`default_nettype none
`include "dcms_defines.vh"

module dcms_top #(
  parameter SYS_CLK_HZ    = `DCMS_SYS_CLK_HZ,
  parameter ONCHIP_NOM_HZ = `DCMS_ONCHIP_NOM_HZ,
  parameter STABLE_PCT    = `DCMS_STABLE_PCT
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire reset_n,
  // Configuration and control
  input  wire outside_gen_on,
  input  wire onchip_gen_on,
  input  wire stop_mode,
  input  wire low_freq_crystal_sel,
  input  wire monitor_on_req,
  input  wire source_write,
  input  wire source_write_val,
  input  wire clock_fail_clr,
  // Clock inputs
  input  wire osc_in_pin,
  input  wire onchip_clock_in,
  input  wire onchip_base_in,
  // Enables
  output reg  amp_enable_r,
  output reg  input_path_enable_r,
  output reg  all_clocks_halt_r,
  output reg  outside_gen_active_r,
  output reg  onchip_gen_active_r,
  // Derived clocks
  output reg  outside_clock_r,
  output reg  outside_ref_clock_r,
  output reg  onchip_ref_clock_r,
  output reg  crystal_settle_clock_r,
  output reg  selected_osc_clock_r,
  output reg  halved_out_clock_r,
  // Status
  output reg  outside_gen_stable_r,
  output reg  onchip_gen_stable_r,
  output wire outside_clock_dead,
  output wire onchip_clock_dead,
  output reg  monitor_on_r,
  output reg  source_select_r,
  output reg  clock_fail_r
);

  // ******************************************************************
  // Period window for the onchip stability measurement
  // ******************************************************************
  localparam integer NOM_PER = SYS_CLK_HZ / ONCHIP_NOM_HZ;
  localparam integer TOL_PER = (NOM_PER * STABLE_PCT) / `DCMS_PERCENT;
  localparam [`DCMS_PER_W-1:0] PER_LO = NOM_PER[`DCMS_PER_W-1:0] - TOL_PER[`DCMS_PER_W-1:0];
  localparam [`DCMS_PER_W-1:0] PER_HI = NOM_PER[`DCMS_PER_W-1:0] + TOL_PER[`DCMS_PER_W-1:0];
  localparam [`DCMS_PER_W-1:0] PER_MAX = {`DCMS_PER_W{1'b1}};

  // Sampled clock levels and their previous values.
  reg onchip_base_r;
  reg onchip_clock_r;
  reg ext_prev_r;
  reg base_prev_r;
  reg onchip_clock_prev_r;
  reg sel_prev_r;

  // Stability measurement.
  reg [`DCMS_PER_W-1:0] per_cnt_r;
  reg [1:0]             good_r;

  // Switch synchronisers, one chain per clock side.
  reg sel_e1_r;
  reg sel_e2_r;
  reg sel_i1_r;
  reg sel_i2_r;

  wire [`DCMS_QUAD_W-1:0] ext_quad;
  wire [`DCMS_QUAD_W-1:0] base_quad;
  wire [`DCMS_LONG_W-1:0] long_cnt;

  wire halt_nxt    = stop_mode;
  wire ext_on_nxt  = outside_gen_on & ~halt_nxt;
  wire int_on_nxt  = onchip_gen_on & ~halt_nxt;
  wire ext_fall    = ext_prev_r & ~outside_clock_r;
  wire base_fall   = base_prev_r & ~onchip_base_r;
  wire onchip_clock_fall   = onchip_clock_prev_r & ~onchip_clock_r;
  wire both_active = outside_gen_active_r & onchip_gen_active_r;

  // The long divider runs on the outside clock while settling or in fast
  // crystal mode, and on the onchip base clock for a slow crystal.
  wire long_on_ext = ~outside_gen_stable_r | ~low_freq_crystal_sel;
  wire long_step   = long_on_ext ? ext_fall : base_fall;
  wire outside_gen_stable_drop   = outside_gen_stable_r & (~outside_gen_on | outside_clock_dead);
  wire long_clr    = ~outside_gen_active_r | outside_gen_stable_drop;
  wire settle_fall = crystal_settle_clock_r & ~long_cnt[`DCMS_SETTLE_BIT];

  wire force_int   = monitor_on_r & outside_clock_dead;
  wire force_ext   = monitor_on_r & onchip_clock_dead;
  wire per_ok      = (per_cnt_r >= PER_LO) && (per_cnt_r <= PER_HI);

  // ******************************************************************
  // Dividers
  // ******************************************************************
  dcms_count #(
    .W (`DCMS_QUAD_W)
  ) u_ext_quad (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clr     (~outside_gen_active_r),
    .step    (ext_fall),
    .cnt_r   (ext_quad)
  );

  dcms_count #(
    .W (`DCMS_QUAD_W)
  ) u_base_quad (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clr     (~onchip_gen_active_r),
    .step    (base_fall),
    .cnt_r   (base_quad)
  );

  dcms_count #(
    .W (`DCMS_LONG_W)
  ) u_long (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clr     (long_clr),
    .step    (long_step),
    .cnt_r   (long_cnt)
  );

  // ******************************************************************
  // Activity detectors
  // ******************************************************************
  dcms_activity #(
    .MISS_LIMIT (`DCMS_MISS_LIMIT)
  ) u_onchip_act (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .enable   (both_active),
    .ref_lvl  (outside_ref_clock_r),
    .mon_fall (base_fall),
    .dead_r   (onchip_clock_dead)
  );

  dcms_activity #(
    .MISS_LIMIT (`DCMS_MISS_LIMIT)
  ) u_outside_act (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .enable   (both_active),
    .ref_lvl  (onchip_ref_clock_r),
    .mon_fall (ext_fall),
    .dead_r   (outside_clock_dead)
  );

  // ******************************************************************
  // Enables and clock sampling
  // ******************************************************************
  // Clock inputs are sampled at the system rate; an onchip clock above a
  // half of the system rate cannot be followed faithfully.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      amp_enable_r         <= 1'b0;
      input_path_enable_r  <= 1'b0;
      all_clocks_halt_r    <= 1'b0;
      outside_gen_active_r <= 1'b0;
      onchip_gen_active_r  <= 1'b0;
      outside_clock_r      <= 1'b0;
      onchip_base_r        <= 1'b0;
      onchip_clock_r       <= 1'b0;
      ext_prev_r           <= 1'b0;
      base_prev_r          <= 1'b0;
      onchip_clock_prev_r          <= 1'b0;
    end else begin
      all_clocks_halt_r    <= halt_nxt;
      amp_enable_r         <= ext_on_nxt;
      input_path_enable_r  <= ext_on_nxt;
      outside_gen_active_r <= ext_on_nxt;
      onchip_gen_active_r  <= int_on_nxt;
      outside_clock_r      <= osc_in_pin & ext_on_nxt;
      onchip_base_r        <= onchip_base_in & int_on_nxt;
      onchip_clock_r       <= onchip_clock_in & int_on_nxt;
      ext_prev_r           <= outside_clock_r;
      base_prev_r          <= onchip_base_r;
      onchip_clock_prev_r          <= onchip_clock_r;
    end
  end

  // ******************************************************************
  // Reference clocks and crystal settle timer
  // ******************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      outside_ref_clock_r    <= 1'b0;
      onchip_ref_clock_r     <= 1'b0;
      crystal_settle_clock_r <= 1'b0;
      outside_gen_stable_r   <= 1'b0;
    end else begin
      if (!outside_gen_stable_r) begin
        outside_ref_clock_r    <= 1'b0;
        onchip_ref_clock_r     <= base_quad[`DCMS_QUAD_BIT];
        crystal_settle_clock_r <= long_cnt[`DCMS_SETTLE_BIT];
      end else if (low_freq_crystal_sel) begin
        outside_ref_clock_r    <= ext_quad[`DCMS_QUAD_BIT];
        onchip_ref_clock_r     <= long_cnt[`DCMS_ONCHIP_REF_CLOCK_LONG_BIT];
        crystal_settle_clock_r <= 1'b0;
      end else begin
        outside_ref_clock_r    <= long_cnt[`DCMS_OUTSIDE_REF_CLOCK_LONG_BIT];
        onchip_ref_clock_r     <= base_quad[`DCMS_QUAD_BIT];
        crystal_settle_clock_r <= 1'b0;
      end
      // Losing the generator or the clock itself wins over a settle edge.
      if (!outside_gen_on || outside_clock_dead || !outside_gen_active_r) begin
        outside_gen_stable_r <= 1'b0;
      end else if (!outside_gen_stable_r && settle_fall) begin
        outside_gen_stable_r <= 1'b1;
      end
    end
  end

  // ******************************************************************
  // Onchip stability measurement
  // ******************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n || !onchip_gen_active_r || onchip_clock_dead) begin
      per_cnt_r           <= {`DCMS_PER_W{1'b0}};
      good_r              <= 2'h0;
      onchip_gen_stable_r <= 1'b0;
    end else if (base_fall) begin
      per_cnt_r <= {{(`DCMS_PER_W-1){1'b0}}, 1'b1};
      if (!per_ok) begin
        good_r              <= 2'h0;
        onchip_gen_stable_r <= 1'b0;
      end else if (good_r == `DCMS_GOOD_LIMIT - 2'h1) begin
        onchip_gen_stable_r <= 1'b1;
      end else begin
        good_r <= good_r + 2'h1;
      end
    end else if (per_cnt_r != PER_MAX) begin
      per_cnt_r <= per_cnt_r + {{(`DCMS_PER_W-1){1'b0}}, 1'b1};
    end
  end

  // ******************************************************************
  // Monitor enable and source select
  // ******************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      monitor_on_r    <= 1'b0;
      source_select_r <= 1'b0;
      clock_fail_r    <= 1'b0;
    end else begin
      if (!monitor_on_req) begin
        monitor_on_r <= 1'b0;
      end else if (!monitor_on_r && onchip_gen_on && outside_gen_on &&
                   onchip_gen_stable_r && outside_gen_stable_r) begin
        monitor_on_r <= 1'b1;
      end
      if (force_int && source_select_r) begin
        source_select_r <= 1'b0;
      end else if (force_ext && !source_select_r) begin
        source_select_r <= 1'b1;
      end else if (source_write && onchip_gen_on && outside_gen_on &&
                   (source_write_val ? outside_gen_stable_r : onchip_gen_stable_r)) begin
        source_select_r <= source_write_val;
      end
      // A new failure in the clearing cycle keeps the flag up.
      if ((force_int && source_select_r) || (force_ext && !source_select_r)) begin
        clock_fail_r <= 1'b1;
      end else if (clock_fail_clr) begin
        clock_fail_r <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Glitch-free switch and divide by two
  // ******************************************************************
  // Each chain advances on its own clock's falling edge, so the gate opens
  // and closes while that clock is low; a monitor force clears a chain at once.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sel_e1_r <= 1'b0;
      sel_e2_r <= 1'b0;
      sel_i1_r <= 1'b1;
      sel_i2_r <= 1'b1;
    end else begin
      if (force_int) begin
        sel_e1_r <= 1'b0;
        sel_e2_r <= 1'b0;
      end else if (ext_fall) begin
        sel_e1_r <= (source_select_r | force_ext) & ~sel_i2_r;
        sel_e2_r <= sel_e1_r;
      end
      if (force_ext) begin
        sel_i1_r <= 1'b0;
        sel_i2_r <= 1'b0;
      end else if (onchip_clock_fall) begin
        sel_i1_r <= (~source_select_r | force_int) & ~sel_e2_r;
        sel_i2_r <= sel_i1_r;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      selected_osc_clock_r <= 1'b0;
      sel_prev_r           <= 1'b0;
      halved_out_clock_r   <= 1'b0;
    end else begin
      selected_osc_clock_r <= (outside_clock_r & sel_e2_r) |
                              (onchip_clock_r & sel_i2_r);
      sel_prev_r           <= selected_osc_clock_r;
      if (selected_osc_clock_r && !sel_prev_r) begin
        halved_out_clock_r <= ~halved_out_clock_r;
      end
    end
  end

endmodule // dcms_top

`default_nettype wire

// file: rtl/dcms_defines.vh
// Shared constants for the dual source clock monitor and selector.
`ifndef DCMS_DEFINES_VH
`define DCMS_DEFINES_VH

// ********************************************************************
// Clock rates
// ********************************************************************
`define DCMS_SYS_CLK_HZ      50000000
`define DCMS_ONCHIP_NOM_HZ   307200
`define DCMS_STABLE_PCT      5
`define DCMS_PERCENT         100

// ********************************************************************
// Divider widths and taps
// ********************************************************************
`define DCMS_QUAD_W          2
`define DCMS_QUAD_BIT        1
`define DCMS_LONG_W          12
`define DCMS_SETTLE_BIT      11
`define DCMS_OUTSIDE_REF_CLOCK_LONG_BIT   8
`define DCMS_ONCHIP_REF_CLOCK_LONG_BIT   5

// ********************************************************************
// Activity and stability counts
// ********************************************************************
`define DCMS_MISS_LIMIT      2'h2
`define DCMS_GOOD_LIMIT      2'h2
`define DCMS_PER_W           9

`endif

// file: rtl/dcms_count.v
// Free running step counter with synchronous clear, used for the divide-by-four and long clock dividers.
`timescale 1ns/100ps
`default_nettype none

module dcms_count #(
  parameter W = 2
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         reset_n,
  // Control
  input  wire         clr,
  input  wire         step,
  // Count
  output reg  [W-1:0] cnt_r
);

  always @(posedge sys_clk) begin
    if (!reset_n || clr) begin
      cnt_r <= {W{1'b0}};
    end else if (step) begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // dcms_count

`default_nettype wire

// file: rtl/dcms_activity.v
// Activity detector: watches one clock against the low phases of a reference.
`timescale 1ns/100ps
`default_nettype none
`include "dcms_defines.vh"

module dcms_activity #(
  parameter [1:0] MISS_LIMIT = `DCMS_MISS_LIMIT
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire reset_n,
  // Inputs
  input  wire enable,
  input  wire ref_lvl,
  input  wire mon_fall,
  // Status
  output reg  dead_r
);

  reg       ref_prev_r;
  reg       seen_r;
  reg [1:0] miss_r;

  always @(posedge sys_clk) begin
    if (!reset_n || !enable) begin
      // Starting high keeps a reference that is already high at enable from
      // passing for the end of a low phase, which would count a false miss.
      ref_prev_r <= 1'b1;
      seen_r     <= 1'b0;
      miss_r     <= 2'h0;
      dead_r     <= 1'b0;
    end else begin
      ref_prev_r <= ref_lvl;
      if (!ref_lvl && mon_fall) begin
        seen_r <= 1'b1;
        miss_r <= 2'h0;
        dead_r <= 1'b0;
      end else if (ref_lvl && !ref_prev_r) begin
        // A low phase of the reference has just ended.
        seen_r <= 1'b0;
        if (seen_r) begin
          miss_r <= 2'h0;
        end else if (miss_r == MISS_LIMIT - 2'h1) begin
          dead_r <= 1'b1;
        end else begin
          miss_r <= miss_r + 2'h1;
        end
      end
    end
  end

endmodule // dcms_activity

`default_nettype wire

// file: tb/dcms_xtal_model.sv
// Behavioural crystal or external clock source driving the oscillator input pin.
`timescale 1ns/100ps
`default_nettype none
module dcms_xtal_model (
  // Clock
  input  wire logic       sys_clk,
  // Control
  input  wire logic       amp_on,
  input  wire logic       run,
  input  wire logic [7:0] half,
  // Pin
  output var  logic       osc_in_pin
);
  // ****************************************
  // Oscillation
  // ****************************************
  logic [7:0] cnt_r = 8'h00;
  initial osc_in_pin = 1'b0;
  // A crystal only swings while the amplifier drives it; a dead one rests low.
  always @(negedge sys_clk) begin
    if (!(amp_on && run)) begin
      cnt_r <= 8'h00;
      osc_in_pin <= 1'b0;
    end else if (cnt_r == half - 8'h01) begin
      cnt_r <= 8'h00;
      osc_in_pin <= ~osc_in_pin;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // dcms_xtal_model
`default_nettype wire

// file: tb/dcms_chk_chk.sv
// Concurrent checks on the ports of the clock monitor and selector.
`timescale 1ns/100ps
`default_nettype none
module dcms_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Controls
  input wire logic outside_gen_on,
  input wire logic onchip_gen_on,
  input wire logic stop_mode,
  input wire logic monitor_on_req,
  input wire logic source_write,
  input wire logic source_write_val,
  input wire logic clock_fail_clr,
  // Watched outputs
  input wire logic amp_enable_r,
  input wire logic input_path_enable_r,
  input wire logic outside_gen_active_r,
  input wire logic onchip_gen_active_r,
  input wire logic outside_ref_clock_r,
  input wire logic crystal_settle_clock_r,
  input wire logic selected_osc_clock_r,
  input wire logic halved_out_clock_r,
  input wire logic outside_gen_stable_r,
  input wire logic onchip_gen_stable_r,
  input wire logic outside_clock_dead,
  input wire logic monitor_on_r,
  input wire logic source_select_r,
  input wire logic clock_fail_r
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire out_run = outside_gen_on && !stop_mode;
  sequence s_dead_sel;
    monitor_on_r && source_select_r && outside_clock_dead;
  endsequence
  sequence s_forced;
    !source_select_r && clock_fail_r;
  endsequence
  AST_AMP: assert property ($past(reset_n, 2) |-> amp_enable_r == $past(out_run))
    else $error("amplifier enable wrong");
  AST_PATH: assert property ($past(reset_n, 2) |-> input_path_enable_r == $past(out_run))
    else $error("input path enable wrong");
  AST_ACT: assert property ($past(reset_n, 2) |-> outside_gen_active_r == $past(out_run)
    && onchip_gen_active_r == $past(onchip_gen_on && !stop_mode)) else $error("active wrong");
  AST_LONG_CLR: assert property (!outside_gen_active_r [*3] |-> !crystal_settle_clock_r)
    else $error("settle divider not held");
  AST_OREF_OFF: assert property (!outside_gen_stable_r [*4] |-> !outside_ref_clock_r)
    else $error("outside reference runs before stable");
  AST_MON_SET: assert property ($rose(monitor_on_r) |-> $past(monitor_on_req && onchip_gen_on
    && outside_gen_on && onchip_gen_stable_r && outside_gen_stable_r)) else $error("monitor set early");
  AST_MON_HOLD: assert property (monitor_on_r && monitor_on_req |=> monitor_on_r)
    else $error("monitor dropped");
  AST_STBL_CLR: assert property ((!outside_gen_on || outside_clock_dead) [*3] |-> !outside_gen_stable_r)
    else $error("outside stable not cleared");
  AST_SEL_LEGAL: assert property ($changed(source_select_r) && !$past(monitor_on_r) |->
    $past(source_write && onchip_gen_on && outside_gen_on && (source_write_val ? outside_gen_stable_r
    : onchip_gen_stable_r)) && source_select_r == $past(source_write_val)) else $error("illegal select");
  AST_FORCE: assert property (s_dead_sel |=> s_forced)
    else $error("no forced switch");
  AST_STICKY: assert property (clock_fail_r && !clock_fail_clr |=> clock_fail_r)
    else $error("failure flag lost");
  AST_HALF: assert property ($rose(selected_osc_clock_r) |-> ##[0:1] $changed(halved_out_clock_r))
    else $error("halved clock missed a toggle");
  AST_RST_SEL: assert property (disable iff (1'b0) !reset_n |=> !source_select_r && !selected_osc_clock_r)
    else $error("reset does not pick onchip clock");
endmodule // dcms_chk
`default_nettype wire

// file: tb/dcms_top_test.sv
// Directed test of the clock monitor and selector through its control ports.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITC(c, n) for (k = 0; k < (n) && !(c); k++) @(negedge sys_clk);
module dcms_top_test;
  // ****************************************
  // Stimulus and status
  // ****************************************
  logic sys_clk = 1'b0, reset_n = 1'b0, outside_gen_on = 1'b0, onchip_gen_on = 1'b0, stop_mode = 1'b0;
  logic low_freq_crystal_sel = 1'b0, monitor_on_req = 1'b0, source_write = 1'b0, source_write_val = 1'b0;
  logic clock_fail_clr = 1'b0, base = 1'b0, oclk = 1'b0, run = 1'b1, oc_q = 1'b0, seen;
  int   n_errors = 0, n_tests = 0, cyc = 0, nfall = 0, bh = 60, bc = 0, cc = 0, p, k;
  wire  osc_in_pin, amp_enable_r, input_path_enable_r, all_clocks_halt_r, outside_gen_active_r;
  wire  onchip_gen_active_r, outside_clock_r, outside_ref_clock_r, onchip_ref_clock_r, crystal_settle_clock_r;
  wire  selected_osc_clock_r, halved_out_clock_r, outside_gen_stable_r, onchip_gen_stable_r;
  wire  outside_clock_dead, onchip_clock_dead, monitor_on_r, source_select_r, clock_fail_r;
  wire  [3:0] mon = {halved_out_clock_r, selected_osc_clock_r, onchip_ref_clock_r, outside_ref_clock_r};
  always #10 sys_clk = ~sys_clk;
  dcms_top dcms_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .outside_gen_on(outside_gen_on),
    .onchip_gen_on(onchip_gen_on), .stop_mode(stop_mode), .low_freq_crystal_sel(low_freq_crystal_sel),
    .monitor_on_req(monitor_on_req), .source_write(source_write), .source_write_val(source_write_val),
    .clock_fail_clr(clock_fail_clr), .osc_in_pin(osc_in_pin), .onchip_clock_in(oclk), .onchip_base_in(base),
    .amp_enable_r(amp_enable_r), .input_path_enable_r(input_path_enable_r),
    .all_clocks_halt_r(all_clocks_halt_r), .outside_gen_active_r(outside_gen_active_r),
    .onchip_gen_active_r(onchip_gen_active_r), .outside_clock_r(outside_clock_r),
    .outside_ref_clock_r(outside_ref_clock_r), .onchip_ref_clock_r(onchip_ref_clock_r),
    .crystal_settle_clock_r(crystal_settle_clock_r), .selected_osc_clock_r(selected_osc_clock_r),
    .halved_out_clock_r(halved_out_clock_r), .outside_gen_stable_r(outside_gen_stable_r),
    .onchip_gen_stable_r(onchip_gen_stable_r), .outside_clock_dead(outside_clock_dead),
    .onchip_clock_dead(onchip_clock_dead), .monitor_on_r(monitor_on_r), .source_select_r(source_select_r),
    .clock_fail_r(clock_fail_r));
  dcms_xtal_model dcms_xtal_model_inst (.sys_clk(sys_clk), .amp_on(amp_enable_r), .run(run),
    .half(8'h02), .osc_in_pin(osc_in_pin));
  // Onchip base clock has a half period of bh cycles; onchip clock has a period of 8 cycles.
  always @(negedge sys_clk) begin
    bc <= (bc >= bh - 1) ? 0 : bc + 1;
    if (bc >= bh - 1) base <= ~base;
    cc <= (cc == 3) ? 0 : cc + 1;
    if (cc == 3) oclk <= ~oclk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    oc_q <= outside_clock_r;
    if (!outside_gen_active_r) nfall <= 0;
    else if (!outside_gen_stable_r && oc_q && !outside_clock_r) nfall <= nfall + 1;
    if (cyc == 80000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic cyc_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr_sel(input logic v);
    @(negedge sys_clk);
    source_write = 1'b1;
    source_write_val = v;
    @(negedge sys_clk);
    source_write = 1'b0;
    cyc_n(2);
  endtask
  // Period of mon[i] in cycles, rising edge to rising edge.
  task automatic per(input int i, output int q);
    int j, r;
    logic v, pv;
    r = 0;
    q = 0;
    pv = 1'b1;
    for (j = 0; j < 30000 && r < 2; j++) begin
      @(negedge sys_clk);
      v = mon[i];
      if (r == 1) q++;
      if (v === 1'b1 && pv === 1'b0) r++;
      pv = v;
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    cyc_n(20);
    `CHK({source_select_r, selected_osc_clock_r}, 2'h0)
    reset_n = 1'b1;
    stop_mode = 1'b1;
    outside_gen_on = 1'b1;
    onchip_gen_on = 1'b1;
    low_freq_crystal_sel = 1'b1;
    cyc_n(3);
    `CHK({amp_enable_r, input_path_enable_r, outside_gen_active_r, all_clocks_halt_r}, 4'h1)
    stop_mode = 1'b0;
    cyc_n(2);
    `CHK({amp_enable_r, input_path_enable_r, outside_gen_active_r, onchip_gen_active_r, all_clocks_halt_r}, 5'h1E)
    per(1, p);
    `CHK(p, 8 * bh)
    `CHK(outside_ref_clock_r, 1'b0)
    monitor_on_req = 1'b1;
    wr_sel(1'b1);
    `CHK({monitor_on_r, source_select_r, onchip_gen_stable_r}, 3'h0)
    monitor_on_req = 1'b0;
    low_freq_crystal_sel = 1'b0;
    bh = 81;
    `WAITC(outside_gen_stable_r === 1'b1, 20000)
    `CHK(nfall, 4096)
    `WAITC(onchip_gen_stable_r === 1'b1, 2000)
    `CHK(onchip_gen_stable_r, 1'b1)
    per(0, p);
    `CHK(p, 2048)
    per(1, p);
    `CHK(p, 648)
    low_freq_crystal_sel = 1'b1;
    per(0, p);
    `CHK(p, 16)
    `WAITC(onchip_clock_dead === 1'b1, 400)
    cyc_n(2);
    `CHK({onchip_clock_dead, onchip_gen_stable_r}, 2'h2)
    low_freq_crystal_sel = 1'b0;
    `WAITC(onchip_clock_dead === 1'b0, 6000)
    `CHK(onchip_clock_dead, 1'b0)
    `WAITC(onchip_gen_stable_r === 1'b1, 2000)
    wr_sel(1'b1);
    `CHK(source_select_r, 1'b1)
    cyc_n(20);
    per(2, p);
    `CHK(p, 4)
    per(3, p);
    `CHK(p, 8)
    wr_sel(1'b0);
    cyc_n(20);
    per(2, p);
    `CHK(p, 8)
    wr_sel(1'b1);
    monitor_on_req = 1'b1;
    cyc_n(3);
    `CHK(monitor_on_r, 1'b1)
    run = 1'b0;
    `WAITC(outside_clock_dead === 1'b1, 3000)
    `CHK(outside_clock_dead, 1'b1)
    cyc_n(3);
    `CHK({source_select_r, clock_fail_r, outside_gen_stable_r, monitor_on_r}, 4'h5)
    cyc_n(20);
    per(2, p);
    `CHK(p, 8)
    clock_fail_clr = 1'b1;
    cyc_n(1);
    clock_fail_clr = 1'b0;
    cyc_n(2);
    `CHK(clock_fail_r, 1'b0)
    monitor_on_req = 1'b0;
    run = 1'b1;
    seen = 1'b0;
    repeat (3000) begin
      @(negedge sys_clk);
      if (outside_ref_clock_r !== 1'b0) seen = 1'b1;
    end
    `CHK({seen, monitor_on_r}, 2'h0)
    outside_gen_on = 1'b0;
    cyc_n(3);
    `CHK({amp_enable_r, outside_gen_stable_r}, 2'h0)
    tally_and_finish();
  end
endmodule // dcms_top_test
bind dcms_top dcms_chk dcms_chk_inst (.sys_clk(sys_clk), .reset_n(reset_n), .outside_gen_on(outside_gen_on),
  .onchip_gen_on(onchip_gen_on), .stop_mode(stop_mode), .monitor_on_req(monitor_on_req),
  .source_write(source_write), .source_write_val(source_write_val), .clock_fail_clr(clock_fail_clr),
  .amp_enable_r(amp_enable_r), .input_path_enable_r(input_path_enable_r),
  .outside_gen_active_r(outside_gen_active_r), .onchip_gen_active_r(onchip_gen_active_r),
  .outside_ref_clock_r(outside_ref_clock_r), .crystal_settle_clock_r(crystal_settle_clock_r),
  .selected_osc_clock_r(selected_osc_clock_r), .halved_out_clock_r(halved_out_clock_r),
  .outside_gen_stable_r(outside_gen_stable_r), .onchip_gen_stable_r(onchip_gen_stable_r),
  .outside_clock_dead(outside_clock_dead), .monitor_on_r(monitor_on_r),
  .source_select_r(source_select_r), .clock_fail_r(clock_fail_r));
`default_nettype wire
